// File: dma_req_cfg.svh
// Purpose: Constants for the two-channel DMA request, end and hint block.
// Assumes: Byte addresses on an AXI4-Lite slave with 32-bit data.
// Notes: Field layouts of the control word live in the package.
`ifndef DMA_REQ_CFG_SVH
`define DMA_REQ_CFG_SVH
`define OFS_SRC 2'h0
`define OFS_DST 2'h1
`define OFS_CNT 2'h2
`define OFS_CTL 2'h3
`define OFS_OPR 8'h20
`define CH_SPAN 8'h20
`define CH_BIT 4
`define OPR_DME 0
`define OPR_NMI_STOP_FLAG 1
`define OPR_AE 2
`define REQ_DELAY 3'h4
`define MODE_INC 2'h1
`define MODE_DEC 2'h2
`define TS_BYTE 2'h0
`define TS_WORD 2'h1
`define TS_16B 2'h3
`define STEP_1 32'h1
`define STEP_2 32'h2
`define STEP_4 32'h4
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// File: dma_req_pkg.sv
// Purpose: Types shared by the DMA request, end and hint block.
// Assumes: One bus clock for all logic.
// Notes: The control word layout is a packed struct.
`default_nettype none
package dma_req_pkg;
  typedef struct packed {
    logic [15:0] upper;
    logic [1:0] dest_addr_mode;
    logic [1:0] src_addr_mode;
    logic [1:0] unit_size;
    logic ar, am, al, ds, dl, tb, ta;
    logic end_irq_enable, end_flag, channel_enable;
  } ctl_t;
  typedef enum logic {BUS_IDLE, BUS_RUN} bus_phase_t;
  typedef struct packed {
    logic [7:0] aw_addr;
    logic aw_valid;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_valid, b_ready;
    logic [7:0] ar_addr;
    logic ar_valid, r_ready;
  } axi_req_t;
  typedef struct packed {
    logic aw_ready, w_ready;
    logic [1:0] b_resp;
    logic b_valid, ar_ready;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic r_valid;
  } axi_rsp_t;
  typedef struct packed {
    logic req, chan;
    logic [31:0] src, dst;
    logic [1:0] unit;
    logic [1:0] sub;
  } dma_cyc_t;
endpackage
`default_nettype wire

// File: dma_request_end_burst_hint.sv
// Purpose: Two-channel DMA request sampling, end control and burst hint.
// Assumes: Bus controller runs one transfer per request and pulses done.
// Notes: Registers reached over AXI4-Lite; channel 0 has priority.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`include "dma_req_cfg.svh"
`default_nettype none
module dma_request_end_burst_hint (
  input wire logic clock,
  input wire logic arst_n,
  input wire dma_req_pkg::axi_req_t axi_req,
  output dma_req_pkg::axi_rsp_t axi_rsp,
  input wire logic [1:0] transfer_request_in,
  output logic [1:0] transfer_ack_out,
  output logic [1:0] end_interrupt,
  output logic burst_hint_n,
  input wire logic nmi_in,
  input wire logic addr_error_in,
  input wire logic mem_is_dram,
  input wire logic dma_done,
  output dma_req_pkg::dma_cyc_t dma_cyc
);

  typedef struct packed {
    logic [31:0] src, dst, cnt;
    dma_req_pkg::ctl_t ctl;
    logic pend, armed;
    logic [2:0] delay;
    logic [1:0] sub;
  } chan_t;

  typedef struct packed {
    chan_t [1:0] ch;
    logic global_enable, nmi_stop_flag, ae;
    dma_req_pkg::bus_phase_t phase;
    logic cur;
    logic [1:0] rq_meta, rq_sync, rq_prev;
    logic aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic hint_n;
  } state_t;

  state_t q, d;
  logic [1:0] rise;
  logic stop_all;

  // Address step for one unit; a 16-byte unit moves in 4-byte pieces.
  function automatic logic [31:0] unit_step(input logic [1:0] ts);
    unique case (ts)
      `TS_BYTE: unit_step = `STEP_1;
      `TS_WORD: unit_step = `STEP_2;
      default: unit_step = `STEP_4;
    endcase
  endfunction

  // Next pointer value for the given address mode.
  function automatic logic [31:0] next_addr(input logic [31:0] a,
                                            input logic [1:0] mode,
                                            input logic [1:0] ts);
    if (mode == `MODE_INC) begin
      next_addr = a + unit_step(ts);
    end else if (mode == `MODE_DEC) begin
      next_addr = a - unit_step(ts);
    end else begin
      next_addr = a;
    end
  endfunction

  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Decoded address is a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && ((a < `CH_SPAN) || (a == `OFS_OPR));
  endfunction

  // Control word pattern that allows the burst hint.
  function automatic logic hint_ok(input dma_req_pkg::ctl_t c);
    hint_ok = (c.upper == 16'h0000) && (c.dest_addr_mode == `MODE_INC) &&
              (c.src_addr_mode == `MODE_INC) &&
              (c.unit_size == `TS_16B) && c.channel_enable;
  endfunction

  // Register read mux; unmapped words read as zero.
  function automatic logic [31:0] read_reg(input state_t s,
                                           input logic [7:0] a);
    chan_t c;
    c = s.ch[a[`CH_BIT]];
    read_reg = 32'h0;
    if (a == `OFS_OPR) begin
      read_reg[`OPR_DME] = s.global_enable;
      read_reg[`OPR_NMI_STOP_FLAG] = s.nmi_stop_flag;
      read_reg[`OPR_AE] = s.ae;
    end else if (mapped(a)) begin
      unique case (a[3:2])
        `OFS_SRC: read_reg = c.src;
        `OFS_DST: read_reg = c.dst;
        `OFS_CNT: read_reg = c.cnt;
        `OFS_CTL: read_reg = c.ctl;
      endcase
    end
  endfunction

  assign rise = q.rq_sync & ~q.rq_prev;
  assign stop_all = ~q.global_enable | q.nmi_stop_flag | q.ae;

  // Bus handshake outputs.
  assign axi_rsp.aw_ready = ~q.aw_full & ~q.b_valid;
  assign axi_rsp.w_ready = ~q.w_full & ~q.b_valid;
  assign axi_rsp.b_valid = q.b_valid;
  assign axi_rsp.b_resp = q.b_resp;
  assign axi_rsp.ar_ready = ~q.r_valid;
  assign axi_rsp.r_valid = q.r_valid;
  assign axi_rsp.r_data = q.r_data;
  assign axi_rsp.r_resp = q.r_resp;

  // Transfer cycle request towards the bus controller.
  assign dma_cyc.req = (q.phase == dma_req_pkg::BUS_RUN);
  assign dma_cyc.chan = q.cur;
  assign dma_cyc.src = q.ch[q.cur].src;
  assign dma_cyc.dst = q.ch[q.cur].dst;
  assign dma_cyc.unit = q.ch[q.cur].ctl.unit_size;
  assign dma_cyc.sub = q.ch[q.cur].sub;
  assign burst_hint_n = q.hint_n;

  // Acknowledge and end interrupt per channel.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      transfer_ack_out[i] = (q.phase == dma_req_pkg::BUS_RUN) &&
                            (q.cur == i[0]) && !q.ch[i].ctl.ar;
      end_interrupt[i] = q.ch[i].ctl.end_flag &&
                         q.ch[i].ctl.end_irq_enable;
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    chan_t c;
    dma_req_pkg::ctl_t wc;
    logic [7:0] wa;
    logic go;
    logic sel;
    c = '0;
    wc = '0;
    wa = q.aw_addr;
    go = 1'b0;
    sel = 1'b0;
    d = q;
    d.rq_meta = transfer_request_in;
    d.rq_sync = q.rq_meta;
    d.rq_prev = q.rq_sync;

    // Write address and data are taken in either order.
    if (axi_req.aw_valid && axi_rsp.aw_ready) begin
      d.aw_full = 1'b1;
      d.aw_addr = axi_req.aw_addr;
    end
    if (axi_req.w_valid && axi_rsp.w_ready) begin
      d.w_full = 1'b1;
      d.w_data = axi_req.w_data;
      d.w_strb = axi_req.w_strb;
    end
    if (q.b_valid && axi_req.b_ready) begin
      d.b_valid = 1'b0;
    end

    // Perform the write once both halves are held.
    if (q.aw_full && q.w_full) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.b_valid = 1'b1;
      d.b_resp = mapped(wa) ? `RESP_OK : `RESP_ERR;
      if (wa == `OFS_OPR) begin
        if (q.w_strb[0]) begin
          d.global_enable = q.w_data[`OPR_DME];
          d.nmi_stop_flag = q.nmi_stop_flag & q.w_data[`OPR_NMI_STOP_FLAG];
          d.ae = q.ae & q.w_data[`OPR_AE];
        end
      end else if (mapped(wa)) begin
        c = q.ch[wa[`CH_BIT]];
        unique case (wa[3:2])
          `OFS_SRC: c.src = merge(c.src, q.w_data, q.w_strb);
          `OFS_DST: c.dst = merge(c.dst, q.w_data, q.w_strb);
          `OFS_CNT: c.cnt = merge(c.cnt, q.w_data, q.w_strb);
          `OFS_CTL: begin
            wc = merge(c.ctl, q.w_data, q.w_strb);
            wc.end_flag = c.ctl.end_flag & wc.end_flag;
            c.ctl = wc;
          end
        endcase
        d.ch[wa[`CH_BIT]] = c;
      end
    end

    // Hardware flag sets follow the software write, so a set wins.
    if (nmi_in) begin
      d.nmi_stop_flag = 1'b1;
    end
    if (addr_error_in) begin
      d.ae = 1'b1;
    end

    // Register read with a defined answer to unmapped words.
    if (axi_req.ar_valid && axi_rsp.ar_ready) begin
      d.r_valid = 1'b1;
      d.r_data = read_reg(q, axi_req.ar_addr);
      d.r_resp = mapped(axi_req.ar_addr) ? `RESP_OK : `RESP_ERR;
    end else if (q.r_valid && axi_req.r_ready) begin
      d.r_valid = 1'b0;
    end

    // Request sampling per channel.
    for (int i = 0; i < 2; i++) begin
      c = d.ch[i];
      if (!c.ctl.channel_enable) begin
        c.pend = 1'b0;
        c.armed = 1'b1;
        c.delay = 3'h0;
        c.sub = 2'h0;
      end else if (c.pend && (c.delay != 3'h0)) begin
        c.delay = c.delay - 3'h1;
      end else if (c.armed && !c.pend && !c.ctl.end_flag && !stop_all) begin
        if (c.ctl.ar) begin
          c.pend = 1'b1;
        end else if (c.ctl.ds ? rise[i] : q.rq_sync[i]) begin
          c.pend = 1'b1;
          c.armed = 1'b0;
          c.delay = `REQ_DELAY;
        end
      end
      d.ch[i] = c;
    end

    // Transfer start and completion.
    unique case (q.phase)
      dma_req_pkg::BUS_IDLE: begin
        for (int i = 1; i >= 0; i--) begin
          c = q.ch[i];
          if (c.ctl.channel_enable && c.pend && (c.delay == 3'h0) &&
              !c.ctl.end_flag && (c.cnt != 32'h0) && !stop_all) begin
            go = 1'b1;
            sel = i[0];
          end
        end
        if (go) begin
          d.phase = dma_req_pkg::BUS_RUN;
          d.cur = sel;
          if (!d.ch[sel].ctl.tb) begin
            d.ch[sel].armed = 1'b1;
          end
        end
      end
      dma_req_pkg::BUS_RUN: begin
        if (dma_done) begin
          // The cycle in flight always completes and updates pointers.
          c = d.ch[q.cur];
          c.src = next_addr(c.src, c.ctl.src_addr_mode, c.ctl.unit_size);
          c.dst = next_addr(c.dst, c.ctl.dest_addr_mode, c.ctl.unit_size);
          c.cnt = c.cnt - 32'h1;
          if (c.ctl.unit_size == `TS_16B) begin
            c.sub = c.sub + 2'h1;
          end
          if (c.cnt == 32'h0) begin
            c.ctl.end_flag = 1'b1;
            c.pend = 1'b0;
            c.armed = 1'b1;
            c.sub = 2'h0;
          end else if (!c.ctl.tb) begin
            c.pend = 1'b0;
          end else if (!c.ctl.ds && !c.ctl.ar) begin
            c.pend = 1'b0;
            c.armed = 1'b1;
          end
          if (!c.ctl.tb && !c.ctl.ar && c.ctl.ds &&
              (c.ctl.unit_size == `TS_16B) && (c.cnt != 32'h0)) begin
            c.armed = 1'b1;
          end
          d.ch[q.cur] = c;
          d.phase = dma_req_pkg::BUS_IDLE;
        end
      end
    endcase

    // Burst hint only while a 16-byte cycle runs to non-DRAM memory.
    d.hint_n = !((d.phase == dma_req_pkg::BUS_RUN) &&
                 hint_ok(d.ch[d.cur].ctl) && !mem_is_dram);
  end

  // State register.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.phase <= dma_req_pkg::BUS_IDLE;
      q.ch[0].armed <= 1'b1;
      q.ch[1].armed <= 1'b1;
      q.hint_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: dma_req_chk.sv
// Purpose: Port-level checker for the DMA request, end and hint block.
// Assumes: One clock domain and an active-low asynchronous reset.
// Notes: Attached to the design top by the bind at the foot.
`default_nettype none
module dma_req_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire dma_req_pkg::axi_req_t axi_req,
  input wire dma_req_pkg::axi_rsp_t axi_rsp,
  input wire logic [1:0] transfer_ack_out,
  input wire logic burst_hint_n,
  input wire logic mem_is_dram,
  input wire logic dma_done,
  input wire dma_req_pkg::dma_cyc_t dma_cyc
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks sample on the bus clock and pause in reset.
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_done;
    dma_cyc.req && dma_done;
  endsequence
  sequence s_aw_w;
    axi_req.aw_valid && axi_rsp.aw_ready && axi_req.w_valid && axi_rsp.w_ready;
  endsequence
  property p_done_ends;
    s_done |=> !dma_cyc.req;
  endproperty
  property p_req_hold;
    dma_cyc.req && !dma_done |=>
      dma_cyc.req && $stable(dma_cyc.src) && $stable(dma_cyc.dst);
  endproperty
  property p_ack;
    transfer_ack_out != 2'h0 |->
      dma_cyc.req && transfer_ack_out == (dma_cyc.chan ? 2'h2 : 2'h1);
  endproperty
  property p_hint;
    !burst_hint_n |-> dma_cyc.req && dma_cyc.unit == 2'h3 &&
      !$past(mem_is_dram);
  endproperty
  property p_bhold;
    axi_rsp.b_valid && !axi_req.b_ready |=> axi_rsp.b_valid;
  endproperty
  property p_rhold;
    axi_rsp.r_valid && !axi_req.r_ready |=>
      axi_rsp.r_valid && $stable(axi_rsp.r_data);
  endproperty
  property p_bresp;
    s_aw_w |-> ##[1:2] axi_rsp.b_valid;
  endproperty
  property p_rresp;
    axi_req.ar_valid && axi_rsp.ar_ready |=> axi_rsp.r_valid;
  endproperty
  a_done_ends: assert property (p_done_ends)
    else $error("transfer request held after done");
  a_req_hold: assert property (p_req_hold)
    else $error("transfer dropped or changed before done");
  a_ack: assert property (p_ack)
    else $error("acknowledge without matching transfer");
  a_hint: assert property (p_hint)
    else $error("burst hint low outside a 16-byte transfer");
  a_bhold: assert property (p_bhold)
    else $error("write response withdrawn early");
  a_rhold: assert property (p_rhold)
    else $error("read data withdrawn early");
  a_bresp: assert property (p_bresp)
    else $error("write response late");
  a_rresp: assert property (p_rresp)
    else $error("read response late");
endmodule
bind dma_request_end_burst_hint dma_req_chk chk (.clock(clock),
  .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .transfer_ack_out(transfer_ack_out), .burst_hint_n(burst_hint_n),
  .mem_is_dram(mem_is_dram), .dma_done(dma_done), .dma_cyc(dma_cyc));
`default_nettype wire

// File: bus_ctrl_model.sv
// Purpose: Bus controller on the far side of the transfer link.
// Assumes: One transfer per request, finished by a one-cycle done.
// Notes: The wait count sets a prompt or slow answer.
`default_nettype none
module bus_ctrl_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic req,
  input wire logic [2:0] wait_cycles,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;
  // Counts the wait, then pulses done for exactly one cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
      done <= 1'b0;
    end else begin
      done <= req && !done && cnt_q == wait_cycles;
      cnt_q <= (req && !done && cnt_q != wait_cycles) ? cnt_q + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the DMA request, end and hint block.
// Assumes: AXI4-Lite master tasks and a bus controller model.
// Notes: Source pointers and wait counts are random from a fixed seed.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, arst_n = 0, nmi = 0, dram = 0, hint_n, done;
  logic [1:0] req_in = 2'h0, ack, irq, rsp;
  logic [2:0] lat = 3'h1;
  logic [31:0] rd, es;
  dma_req_pkg::axi_req_t rq = '0;
  dma_req_pkg::axi_rsp_t rs;
  dma_req_pkg::dma_cyc_t cyc;
  int miscompares = 0, tests_run = 0, n;
  integer seed = 32'h6f76df66;
  // Free-running bus clock.
  always #50 clock = ~clock;
  dma_request_end_burst_hint uut (.clock(clock), .arst_n(arst_n),
    .axi_req(rq), .axi_rsp(rs), .transfer_request_in(req_in),
    .transfer_ack_out(ack), .end_interrupt(irq), .burst_hint_n(hint_n),
    .nmi_in(nmi), .addr_error_in(1'b0), .mem_is_dram(dram),
    .dma_done(done), .dma_cyc(cyc));
  bus_ctrl_model bcm (.clock(clock), .arst_n(arst_n), .req(cyc.req),
    .wait_cycles(lat), .done(done));
  // Compares and reports one value.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Ends the run when a bounded wait ran out.
  task automatic lim;
    if (n >= 200) begin
      miscompares++;
      complete_run;
    end
  endtask
  // Readies are taken at the falling edge, so the rising edge acts on them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awt, wt, bt;
    @(posedge clock);
    rq.aw_addr <= a;
    rq.w_data <= d;
    rq.w_strb <= 4'hf;
    {rq.aw_valid, rq.w_valid, rq.b_ready} <= 3'h7;
    n = 0;
    do begin
      @(negedge clock);
      awt = rs.aw_ready;
      wt = rs.w_ready;
      bt = rs.b_valid;
      @(posedge clock);
      if (awt) rq.aw_valid <= 1'b0;
      if (wt) rq.w_valid <= 1'b0;
      n++;
    end while (!bt && n < 200);
    rq.b_ready <= 1'b0;
    lim();
  endtask
  task automatic rdr(input logic [7:0] a);
    logic art, rt;
    @(posedge clock);
    rq.ar_addr <= a;
    {rq.ar_valid, rq.r_ready} <= 2'h3;
    n = 0;
    do begin
      @(negedge clock);
      art = rs.ar_ready;
      rt = rs.r_valid;
      rd = rs.r_data;
      rsp = rs.r_resp;
      @(posedge clock);
      if (art) rq.ar_valid <= 1'b0;
      n++;
    end while (!rt && n < 200);
    rq.r_ready <= 1'b0;
    lim();
  endtask
  task automatic wait_req(input logic v);
    n = 0;
    @(negedge clock);
    while (cyc.req !== v && n < 200) begin
      @(negedge clock);
      n++;
    end
    lim();
  endtask
  // Checks one transfer against the pointer model, then advances it.
  task automatic xfer(input logic c, input logic [31:0] st,
                      input logic [1:0] a, input logic h);
    wait_req(1'b1);
    chk(cyc.chan, c);
    chk(cyc.src, es);
    chk(ack, a);
    @(negedge clock);
    chk(hint_n, h);
    es = es + st;
    lat <= 3'h1 + 3'($random(seed) & 3);
    wait_req(1'b0);
  endtask
  task automatic pulse;
    @(posedge clock);
    req_in[0] <= 1'b1;
    repeat (3) @(posedge clock);
    req_in[0] <= 1'b0;
  endtask
  // Main sequence: reset, register checks, edge requests, hint and halt.
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rdr(8'h0c);
    chk(rd, 32'h0);
    rdr(8'h40);
    chk(rsp, `RESP_ERR);
    es = $random(seed);
    wr(8'h00, es);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h1045);
    wr(8'h20, 32'h1);
    repeat (2) begin
      pulse();
      xfer(1'b0, 32'h1, 2'h1, 1'b1);
    end
    rdr(8'h08);
    chk(rd, 32'h0);
    pulse();
    repeat (20) @(posedge clock);
    chk(cyc.req, 1'b0);
    chk(irq, 2'h1);
    wr(8'h0c, 32'h1045);
    chk(irq, 2'h0);
    lat <= 3'h7;
    es = $random(seed) & 32'hfffffff0;
    wr(8'h10, es);
    wr(8'h18, 32'h8);
    wr(8'h1c, 32'h5e01);
    repeat (3) xfer(1'b1, 32'h4, 2'h0, 1'b0);
    wait_req(1'b1);
    @(posedge clock);
    nmi <= 1'b1;
    @(posedge clock);
    nmi <= 1'b0;
    xfer(1'b1, 32'h4, 2'h0, 1'b0);
    repeat (20) begin
      @(posedge clock);
      chk(cyc.req, 1'b0);
    end
    rdr(8'h20);
    chk(rd[2:0], 3'h3);
    rdr(8'h18);
    chk(rd, 32'h4);
    dram <= 1'b1;
    wr(8'h20, 32'h1);
    repeat (4) xfer(1'b1, 32'h4, 2'h0, 1'b1);
    rdr(8'h1c);
    chk(rd[1], 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
